/* File: design/mab_datapath.sv */
// Purpose: Execution datapath for add-immediate, AND and single-bit set/clear
// Assumes: Decoder presents one operation per enabled cycle with its operands
// Notes:   Work register and flags live here; data-register writes go out registered
`timescale 1ns/1ps

module mab_datapath
   import mab_pkg::*;
(
   input  wire logic                          clk,             // Core instruction clock
   input  wire logic                          reset_n,         // Synchronous reset, active low
   input  wire logic                          clk_en,          // Freezes all state while low
   input  wire logic                          op_valid,        // Operation presented this cycle
   input  wire mab_pkg::mab_op_t              op_code,         // Decoded operation
   input  wire logic [mab_pkg::DATA_W-1:0]    imm_data,        // 8-bit immediate
   input  wire logic [mab_pkg::ADDR_W-1:0]    reg_addr,        // Data register index
   input  wire logic [mab_pkg::BIT_SEL_W-1:0] bit_sel,         // Bit position for set/clear
   input  wire logic                          dest_select,     // 0 work register, 1 data register
   input  wire logic [mab_pkg::DATA_W-1:0]    reg_rd_data,     // Addressed data register value
   output logic      [mab_pkg::DATA_W-1:0]    work_reg,        // Accumulator
   output logic                               zero_flag,       // Result was zero
   output logic                               half_carry_flag, // Carry out of bit 3
   output logic                               carry_flag,      // Carry out of bit 7
   output logic                               reg_wr_en,       // One-cycle data register write
   output logic      [mab_pkg::ADDR_W-1:0]    reg_wr_addr,     // Write index
   output logic      [mab_pkg::DATA_W-1:0]    reg_wr_data      // Write value
);
   import mab_pkg::*;

   logic [DATA_W-1:0]   work_next;
   logic                zero_next;
   logic                half_next;
   logic                carry_next;
   logic                flags_z_upd;
   logic                flags_c_upd;
   logic                wr_en_next;
   logic [DATA_W-1:0]   wr_data_next;
   logic                fire;
   logic                carry_in;
   logic [DATA_W:0]     sum_full;
   logic [NIBBLE_W:0]   sum_low;
   logic [DATA_W-1:0]   reg_operand;
   logic [DATA_W-1:0]   and_reg_res;
   logic [DATA_W-1:0]   bit_mask;

   assign fire = clk_en && op_valid;

   // Forward a pending write so back-to-back ops on one register see fresh data
   assign reg_operand = (reg_wr_en && reg_wr_addr == reg_addr) ? reg_wr_data : reg_rd_data;

   assign carry_in = (op_code == MAB_ADD_IMM_WITH_CARRY_OP) ? carry_flag : 1'b0;
   assign sum_full = {1'b0, work_reg} + {1'b0, imm_data} + {{DATA_W{1'b0}}, carry_in};
   assign sum_low  = {1'b0, work_reg[NIBBLE_W-1:0]} + {1'b0, imm_data[NIBBLE_W-1:0]}
                   + {{NIBBLE_W{1'b0}}, carry_in};
   assign and_reg_res = work_reg & reg_operand;
   assign bit_mask    = ONE_HOT_LSB << bit_sel;

   always_comb begin
      work_next    = work_reg;
      wr_en_next   = 1'b0;
      wr_data_next = reg_wr_data;
      flags_z_upd  = 1'b0;
      flags_c_upd  = 1'b0;
      case (op_code)
         MAB_ADD_IMM_WITH_CARRY_OP, MAB_ADD_IMM_OP: begin
            work_next   = sum_full[DATA_W-1:0];
            flags_z_upd = 1'b1;
            flags_c_upd = 1'b1;
         end
         MAB_AND_IMM_OP: begin
            work_next   = work_reg & imm_data;
            flags_z_upd = 1'b1;
         end
         MAB_AND_REG_OP: begin
            flags_z_upd = 1'b1;
            if (dest_select == DEST_REG) begin
               wr_en_next   = 1'b1;
               wr_data_next = and_reg_res;
            end else begin
               work_next = and_reg_res;
            end
         end
         MAB_BIT_CLEAR_OP: begin
            wr_en_next   = 1'b1;
            wr_data_next = reg_operand & ~bit_mask;
         end
         MAB_BIT_SET_OP: begin
            wr_en_next   = 1'b1;
            wr_data_next = reg_operand | bit_mask;
         end
         default: begin
            work_next = work_reg;
         end
      endcase
   end

   // Zero tracks whichever byte the operation produced
   always_comb begin
      if (op_code == MAB_AND_REG_OP) begin
         zero_next = (and_reg_res == ZERO_BYTE);
      end else begin
         zero_next = (work_next == ZERO_BYTE);
      end
      half_next  = sum_low[NIBBLE_W];
      carry_next = sum_full[DATA_W];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         work_reg <= WORK_RESET;
      end else if (fire) begin
         work_reg <= work_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         zero_flag       <= FLAG_RESET;
         half_carry_flag <= FLAG_RESET;
         carry_flag      <= FLAG_RESET;
      end else if (fire) begin
         if (flags_z_upd) begin
            zero_flag <= zero_next;
         end
         if (flags_c_upd) begin
            half_carry_flag <= half_next;
            carry_flag      <= carry_next;
         end
      end
   end

   // Write strobe lasts one enabled cycle; it holds its value while frozen
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_wr_en   <= 1'b0;
         reg_wr_addr <= ADDR_RESET;
         reg_wr_data <= ZERO_BYTE;
      end else if (clk_en) begin
         reg_wr_en <= op_valid && wr_en_next;
         if (op_valid && wr_en_next) begin
            reg_wr_addr <= reg_addr;
            reg_wr_data <= wr_data_next;
         end
      end
   end

   // Checks
   sequence issue_s(mab_op_t op);
      clk_en && op_valid && op_code == op;
   endsequence

   sequence issue_reg_dest_s(mab_op_t op);
      issue_s(op) ##0 dest_select == DEST_REG;
   endsequence

   // Sums rebuilt from the operands, not taken from the adder above
   property add_result_p(mab_op_t op, logic cin_used);
      @(posedge clk) disable iff (!reset_n)
      issue_s(op) |=> {carry_flag, work_reg} == 9'($past(work_reg)) + 9'($past(imm_data))
         + 9'($past(carry_flag) && cin_used)
         && half_carry_flag == ((5'($past(work_reg[NIBBLE_W-1:0])) + 5'($past(imm_data[NIBBLE_W-1:0]))
         + 5'($past(carry_flag) && cin_used)) > 5'h0F);
   endproperty

   add_carry_in_a: assert property (add_result_p(MAB_ADD_IMM_WITH_CARRY_OP, 1'b1))
      else $error("add with carry result or flags wrong");

   add_flags_a: assert property (add_result_p(MAB_ADD_IMM_OP, 1'b0))
      else $error("add immediate carry or half carry wrong");

   add_no_carry_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_s(MAB_ADD_IMM_OP) |=> work_reg == 8'($past(work_reg) + $past(imm_data)))
      else $error("add immediate included carry or wrong sum");

   and_reg_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_s(MAB_AND_REG_OP) |=> $stable(carry_flag) && $stable(half_carry_flag)
         && zero_flag == ($past(and_reg_res) == ZERO_BYTE))
      else $error("register AND touched carry flags or zero wrong");

   // Strobe drops after one cycle unless a new op was taken or the block was frozen
   dest_reg_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_reg_dest_s(MAB_AND_REG_OP) |=> reg_wr_en && reg_wr_addr == $past(reg_addr)
         && reg_wr_data == $past(and_reg_res) && $stable(work_reg)
         ##1 !reg_wr_en || $past(fire) || !$past(clk_en))
      else $error("register destination not written");

   dest_work_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_s(MAB_AND_REG_OP) ##0 dest_select == DEST_WORK |=> !reg_wr_en && work_reg == $past(and_reg_res))
      else $error("work destination not taken");

   and_imm_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_s(MAB_AND_IMM_OP) |=> work_reg == ($past(work_reg) & $past(imm_data))
         && $stable(carry_flag) && $stable(half_carry_flag) && zero_flag == (work_reg == ZERO_BYTE))
      else $error("immediate AND wrong");

   bit_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_s(MAB_BIT_CLEAR_OP) |=> reg_wr_en && !reg_wr_data[$past(bit_sel)]
         && (reg_wr_data | $past(bit_mask)) == ($past(reg_operand) | $past(bit_mask))
         && $stable({zero_flag, half_carry_flag, carry_flag}))
      else $error("bit clear wrong");

   bit_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_s(MAB_BIT_SET_OP) |=> reg_wr_en && reg_wr_addr == $past(reg_addr) && reg_wr_data[$past(bit_sel)]
         && (reg_wr_data & ~$past(bit_mask)) == ($past(reg_operand) & ~$past(bit_mask))
         && $stable({zero_flag, half_carry_flag, carry_flag}))
      else $error("bit set wrong");

   frozen_state_a: assert property (@(posedge clk) disable iff (!reset_n)
      !clk_en |=> $stable(work_reg) && $stable({zero_flag, half_carry_flag, carry_flag})
         && $stable({reg_wr_en, reg_wr_addr, reg_wr_data}))
      else $error("state changed while clock enable low");

   zero_work_a: assert property (@(posedge clk) disable iff (!reset_n)
      issue_s(MAB_ADD_IMM_OP) or issue_s(MAB_ADD_IMM_WITH_CARRY_OP)
         |=> zero_flag == (work_reg == ZERO_BYTE))
      else $error("zero flag disagrees with sum");
endmodule

/* File: shared/mab_pkg.sv */
// Purpose: Shared constants and types for the add and bit-operation datapath
// Assumes: 8-bit data, 128 data registers, one instruction per enabled cycle
// Notes:   Operation codes are Gray-ordered along the usual issue sequence
package mab_pkg;
   localparam int DATA_W      = 8;
   localparam int ADDR_W      = 7;
   localparam int BIT_SEL_W   = 3;
   localparam int NIBBLE_W    = 4;
   localparam int OP_W        = 3;
   localparam int CYCLES_PER_OP = 1;

   localparam logic [ADDR_W-1:0]  REG_ADDR_LAST = 7'h7F;
   localparam logic [BIT_SEL_W-1:0] BIT_SEL_LAST = 3'h7;
   localparam logic [DATA_W-1:0]  WORK_RESET    = 8'h00;
   localparam logic [DATA_W-1:0]  ZERO_BYTE     = 8'h00;
   localparam logic [DATA_W-1:0]  ONE_HOT_LSB   = 8'h01;
   localparam logic [ADDR_W-1:0]  ADDR_RESET    = 7'h00;
   localparam logic               FLAG_RESET    = 1'b0;
   localparam logic               DEST_WORK     = 1'b0;
   localparam logic               DEST_REG      = 1'b1;

   typedef enum logic [OP_W-1:0] {
      MAB_NONE_OP               = 3'h0,
      MAB_ADD_IMM_WITH_CARRY_OP = 3'h1,
      MAB_ADD_IMM_OP            = 3'h3,
      MAB_AND_IMM_OP            = 3'h2,
      MAB_AND_REG_OP            = 3'h6,
      MAB_BIT_SET_OP            = 3'h7,
      MAB_BIT_CLEAR_OP          = 3'h5
   } mab_op_t;
endpackage

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the add and bit-operation datapath
// Assumes: Register file is modelled by driving reg_rd_data per operation
// Notes:   Operations idle a cycle apart, except in t_fwd, which runs them back to back
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_errors++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module tb;
   import mab_pkg::*;
   logic          clk = 1'b0;
   logic          reset_n = 1'b0;
   logic          clk_en = 1'b1;
   logic          op_valid = 1'b0;
   logic          dest_select = 1'b0;
   mab_op_t       op_code = MAB_NONE_OP;
   logic [7:0]    imm_data = 8'h00;
   logic [7:0]    reg_rd_data = 8'h00;
   logic [6:0]    reg_addr = 7'h00;
   logic [2:0]    bit_sel = 3'h0;
   logic [7:0]    work_reg;
   logic [7:0]    reg_wr_data;
   logic [6:0]    reg_wr_addr;
   logic          zero_flag;
   logic          half_carry_flag;
   logic          carry_flag;
   logic          reg_wr_en;
   int            n_errors = 0;
   int            compares = 0;

   always #5 clk = ~clk;

   mab_datapath mab_datapath_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .op_valid(op_valid),
      .op_code(op_code), .imm_data(imm_data), .reg_addr(reg_addr), .bit_sel(bit_sel),
      .dest_select(dest_select), .reg_rd_data(reg_rd_data), .work_reg(work_reg), .zero_flag(zero_flag),
      .half_carry_flag(half_carry_flag), .carry_flag(carry_flag), .reg_wr_en(reg_wr_en),
      .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));

   task automatic finish_test;
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Presents one operation for one edge, then idles; returns with results settled
   task automatic do_op(input mab_op_t op, input logic [7:0] imm, input logic [7:0] rd = 8'h00,
                        input logic [6:0] addr = 7'h00, input logic [2:0] b = 3'h0,
                        input logic d = 1'b0, input logic en = 1'b1);
      @(posedge clk);
      #1;
      clk_en = en;
      op_valid = 1'b1;
      op_code = op;
      imm_data = imm;
      reg_rd_data = rd;
      reg_addr = addr;
      bit_sel = b;
      dest_select = d;
      @(posedge clk);
      #1;
      op_valid = 1'b0;
      clk_en = 1'b1;
   endtask

   task automatic chk(input logic [7:0] w, input logic z, input logic h, input logic c, input logic we);
      `CHK("work_reg", w, work_reg)
      `CHK("zero_flag", z, zero_flag)
      `CHK("half_carry_flag", h, half_carry_flag)
      `CHK("carry_flag", c, carry_flag)
      `CHK("reg_wr_en", we, reg_wr_en)
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      `CHK("reg_wr_addr", a, reg_wr_addr)
      `CHK("reg_wr_data", v, reg_wr_data)
   endtask

   task automatic t_reset;
      chk(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(7'h00, 8'h00);
   endtask

   task automatic t_add;
      do_op(MAB_ADD_IMM_OP, 8'h12); chk(8'h12, 1'b0, 1'b0, 1'b0, 1'b0);
      do_op(MAB_ADD_IMM_OP, 8'h34); chk(8'h46, 1'b0, 1'b0, 1'b0, 1'b0);
      do_op(MAB_ADD_IMM_OP, 8'hCA); chk(8'h10, 1'b0, 1'b1, 1'b1, 1'b0);
      do_op(MAB_ADD_IMM_WITH_CARRY_OP, 8'hEF); chk(8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
      do_op(MAB_ADD_IMM_OP, 8'h01); chk(8'h01, 1'b0, 1'b0, 1'b0, 1'b0);
      do_op(MAB_ADD_IMM_WITH_CARRY_OP, 8'h0E); chk(8'h0F, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask

   task automatic t_and;
      do_op(MAB_ADD_IMM_OP, 8'hF0); chk(8'hFF, 1'b0, 1'b0, 1'b0, 1'b0);
      do_op(MAB_ADD_IMM_OP, 8'h5B); chk(8'h5A, 1'b0, 1'b1, 1'b1, 1'b0);
      do_op(MAB_AND_REG_OP, 8'h00, 8'hAF, 7'h7F, 3'h0, 1'b1); chk(8'h5A, 1'b0, 1'b1, 1'b1, 1'b1);
      wr(7'h7F, 8'h0A);
      @(posedge clk);
      #1;
      `CHK("reg_wr_en", 1'b0, reg_wr_en)
      do_op(MAB_AND_IMM_OP, 8'hAF); chk(8'h0A, 1'b0, 1'b1, 1'b1, 1'b0);
      do_op(MAB_AND_REG_OP, 8'h00, 8'h50, 7'h05); chk(8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
   endtask

   // Opposite ends of the address range, every bit position
   task automatic t_bits;
      for (int b = 0; b < 8; b++) begin
         do_op(MAB_BIT_SET_OP, 8'h00, 8'h00, 7'h00, b[2:0]); chk(8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
         wr(7'h00, 8'h01 << b);
         do_op(MAB_BIT_CLEAR_OP, 8'h00, 8'hFF, 7'h7F, b[2:0]); chk(8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
         wr(7'h7F, ~(8'h01 << b));
      end
   endtask

   // Stale register read on back-to-back ops; the pending write must be bypassed
   task automatic t_fwd;
      @(posedge clk);
      #1;
      op_valid = 1'b1;
      op_code = MAB_BIT_SET_OP;
      reg_rd_data = 8'h00;
      reg_addr = 7'h10;
      bit_sel = 3'h1;
      @(posedge clk);
      #1;
      bit_sel = 3'h6;
      wr(7'h10, 8'h02);
      @(posedge clk);
      #1;
      clk_en = 1'b0;
      op_code = MAB_BIT_CLEAR_OP;
      wr(7'h10, 8'h42);
      @(posedge clk);
      #1;
      clk_en = 1'b1;
      `CHK("reg_wr_en", 1'b1, reg_wr_en)
      wr(7'h10, 8'h42);
      @(posedge clk);
      #1;
      op_valid = 1'b0;
      chk(8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
      wr(7'h10, 8'h02);
   endtask

   task automatic t_hold;
      do_op(MAB_ADD_IMM_OP, 8'h11, 8'h00, 7'h00, 3'h0, 1'b0, 1'b0); chk(8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
      do_op(mab_op_t'(3'h4), 8'h11); chk(8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
      @(posedge clk);
      #1;
      reset_n = 1'b0;
      @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_reset;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_reset;
      t_add;
      t_and;
      t_bits;
      t_fwd;
      t_hold;
      finish_test;
   end

   // Whole run needs well under 100 cycles
   initial begin
      #20000;
      n_errors++;
      finish_test;
   end
endmodule
